// ===== hdl/dacc_pkg.sv
package dacc_pkg;

	// Primary and untranslated alias addresses of the three registers.
	localparam logic [31:0] DACC_ADDR_DATA_CH0 = 32'h040000a0;
	localparam logic [31:0] DACC_ADDR_DATA_CH1 = 32'h040000a2;
	localparam logic [31:0] DACC_ADDR_CONTROL = 32'h040000a4;
	localparam logic [31:0] DACC_ALIAS_DATA_CH0 = 32'ha40000a0;
	localparam logic [31:0] DACC_ALIAS_DATA_CH1 = 32'ha40000a2;
	localparam logic [31:0] DACC_ALIAS_CONTROL = 32'ha40000a4;

	localparam logic [7:0] DACC_DATA_RST = 8'h00;
	localparam logic [7:0] DACC_CONTROL_RST = 8'h1f;
	localparam logic [7:0] DACC_CONTROL_RO_ONES = 8'h1f;
	localparam logic [7:0] DACC_UNMAPPED_READ = 8'h00;

	localparam int DACC_BIT_OUT_EN_CH1 = 7;
	localparam int DACC_BIT_OUT_EN_CH0 = 6;
	localparam int DACC_BIT_JOINT_EN = 5;

	localparam int DACC_SETTLE_NS = 10000;
	localparam int DACC_CLK_NS = 40;
	// Longest time, so the division rounds down.
	localparam int DACC_SETTLE_CYC = DACC_SETTLE_NS / DACC_CLK_NS;
	localparam int DACC_CNT_W = 16;

	typedef enum logic [1:0] {
		DACC_ST_IDLE = 2'b00,
		DACC_ST_WAIT = 2'b01,
		DACC_ST_VALID = 2'b11
	} dacc_st_t;

	typedef enum logic [1:0] {
		DACC_SEL_NONE = 2'b00,
		DACC_SEL_CH0 = 2'b01,
		DACC_SEL_CH1 = 2'b11,
		DACC_SEL_CTRL = 2'b10
	} dacc_sel_t;

endpackage

// ===== hdl/dacc_settle.sv
`timescale 1ns/1ps
module dacc_settle
	import dacc_pkg::*;
#(
	parameter int SETTLE_CYC = DACC_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic conv_en,
	input wire logic [7:0] code,
	output logic valid
);

	// The count is loaded with two less, so it must fit and not go negative.
	if (SETTLE_CYC < 2 || SETTLE_CYC >= 2 ** DACC_CNT_W) begin : g_bad_cyc
		$error("dacc_settle: SETTLE_CYC out of range");
	end

	localparam logic [DACC_CNT_W-1:0] LOAD = DACC_CNT_W'(SETTLE_CYC - 2);

	typedef struct packed {
		dacc_st_t st;
		logic [DACC_CNT_W-1:0] cnt;
		logic [7:0] last;
	} dacc_settle_state_t;

	dacc_settle_state_t s_q, s_d;

	// A new enable or a new code restarts the settling count at once.
	always_comb begin
		s_d = s_q;
		s_d.last = code;
		if (!conv_en) begin
			s_d.st = DACC_ST_IDLE;
			s_d.cnt = '0;
		end else if (s_q.st == DACC_ST_IDLE || code != s_q.last) begin
			s_d.st = DACC_ST_WAIT;
			s_d.cnt = LOAD;
		end else begin
			unique case (s_q.st)
				DACC_ST_WAIT: begin
					if (s_q.cnt == '0) begin
						s_d.st = DACC_ST_VALID;
					end else begin
						s_d.cnt = s_q.cnt - 1'b1;
					end
				end
				DACC_ST_VALID: begin
					s_d.st = DACC_ST_VALID;
				end
				default: begin
					s_d.st = DACC_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '{st: DACC_ST_IDLE, cnt: '0, last: DACC_DATA_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign valid = (s_q.st == DACC_ST_VALID);

	// Helper: cycles since the last restart of the count.
	logic [DACC_CNT_W-1:0] age_q;
	always_ff @(posedge clk) begin
		if (sys_rst || !conv_en || s_q.st == DACC_ST_IDLE
				|| code != s_q.last) begin
			age_q <= '0;
		end else if (age_q != '1) begin
			age_q <= age_q + 1'b1;
		end
	end

	AST_SETTLE_BOUND: assert property (@(posedge clk)
		disable iff (sys_rst)
		(conv_en && age_q >= DACC_CNT_W'(SETTLE_CYC - 1)) |-> valid)
		else $error("output not valid within settling time");
	AST_SETTLE_EARLY: assert property (@(posedge clk)
		disable iff (sys_rst)
		(valid |-> age_q >= DACC_CNT_W'(SETTLE_CYC - 2)))
		else $error("output valid before settling time");
	AST_SETTLE_RESTART: assert property (@(posedge clk)
		disable iff (sys_rst)
		(conv_en && code != s_q.last) |=> !valid)
		else $error("new code did not restart conversion");
	AST_SETTLE_OFF: assert property (@(posedge clk)
		disable iff (sys_rst)
		!conv_en |=> !valid)
		else $error("valid while conversion disabled");

endmodule

// ===== hdl/dacc_top.sv
`timescale 1ns/1ps
module dacc_top
	import dacc_pkg::*;
#(
	parameter int SETTLE_CYC = DACC_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic bus_ack,
	output logic [7:0] analog_out_ch0,
	output logic [7:0] analog_out_ch1,
	output logic conv_en_ch0,
	output logic conv_en_ch1,
	output logic out_en_ch0,
	output logic out_en_ch1,
	output logic out_valid_ch0,
	output logic out_valid_ch1
);

	////////////////////////////////////////////////////////////////////////

	// The settling timers cannot serve a count below two or beyond their width.
	if (SETTLE_CYC < 2 || SETTLE_CYC >= 2 ** DACC_CNT_W) begin : g_bad_cyc
		$error("dacc_top: SETTLE_CYC out of range");
	end

	// Both the translated and the alias address select the same register.
	function automatic dacc_sel_t dacc_decode(input logic [31:0] a);
		dacc_sel_t sel;
		sel = DACC_SEL_NONE;
		if (a == DACC_ADDR_DATA_CH0 || a == DACC_ALIAS_DATA_CH0) begin
			sel = DACC_SEL_CH0;
		end else if (a == DACC_ADDR_DATA_CH1 || a == DACC_ALIAS_DATA_CH1) begin
			sel = DACC_SEL_CH1;
		end else if (a == DACC_ADDR_CONTROL || a == DACC_ALIAS_CONTROL) begin
			sel = DACC_SEL_CTRL;
		end
		return sel;
	endfunction

	typedef struct packed {
		logic [7:0] data_ch0;
		logic [7:0] data_ch1;
		logic out_en_ch1;
		logic out_en_ch0;
		logic joint_convert_en;
		logic [7:0] rdata;
		logic ack;
	} dacc_state_t;

	dacc_state_t s_q, s_d;
	dacc_sel_t sel;
	logic [7:0] dac_control;

	assign sel = dacc_decode(bus_addr);
	assign dac_control = {s_q.out_en_ch1, s_q.out_en_ch0,
		s_q.joint_convert_en, DACC_CONTROL_RO_ONES[4:0]};

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_d = s_q;
		s_d.ack = bus_wr || bus_rd;
		if (bus_wr) begin
			unique case (sel)
				DACC_SEL_CH0: s_d.data_ch0 = bus_wdata;
				DACC_SEL_CH1: s_d.data_ch1 = bus_wdata;
				DACC_SEL_CTRL: begin
					s_d.out_en_ch1 = bus_wdata[DACC_BIT_OUT_EN_CH1];
					s_d.out_en_ch0 = bus_wdata[DACC_BIT_OUT_EN_CH0];
					s_d.joint_convert_en = bus_wdata[DACC_BIT_JOINT_EN];
				end
				DACC_SEL_NONE: begin
					s_d.data_ch0 = s_q.data_ch0;
				end
			endcase
		end
		if (bus_rd) begin
			unique case (sel)
				DACC_SEL_CH0: s_d.rdata = s_q.data_ch0;
				DACC_SEL_CH1: s_d.rdata = s_q.data_ch1;
				DACC_SEL_CTRL: s_d.rdata = dac_control;
				DACC_SEL_NONE: s_d.rdata = DACC_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q.data_ch0 <= DACC_DATA_RST;
			s_q.data_ch1 <= DACC_DATA_RST;
			s_q.out_en_ch1 <= DACC_CONTROL_RST[DACC_BIT_OUT_EN_CH1];
			s_q.out_en_ch0 <= DACC_CONTROL_RST[DACC_BIT_OUT_EN_CH0];
			s_q.joint_convert_en <= DACC_CONTROL_RST[DACC_BIT_JOINT_EN];
			s_q.rdata <= 8'h00;
			s_q.ack <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////

	logic any_out_en;
	assign any_out_en = s_q.out_en_ch0 || s_q.out_en_ch1;
	assign conv_en_ch0 = s_q.out_en_ch0
		|| (s_q.joint_convert_en && any_out_en);
	assign conv_en_ch1 = s_q.out_en_ch1
		|| (s_q.joint_convert_en && any_out_en);
	assign out_en_ch0 = s_q.out_en_ch0;
	assign out_en_ch1 = s_q.out_en_ch1;
	assign analog_out_ch0 = s_q.data_ch0;
	assign analog_out_ch1 = s_q.data_ch1;
	assign bus_rdata = s_q.rdata;
	assign bus_ack = s_q.ack;

	// One settling timer per channel keeps the channels independent.
	dacc_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle_ch0 (
		.clk(clk),
		.sys_rst(sys_rst),
		.conv_en(conv_en_ch0),
		.code(s_q.data_ch0),
		.valid(out_valid_ch0)
	);

	dacc_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle_ch1 (
		.clk(clk),
		.sys_rst(sys_rst),
		.conv_en(conv_en_ch1),
		.code(s_q.data_ch1),
		.valid(out_valid_ch1)
	);

	////////////////////////////////////////////////////////////////////////

	sequence seq_wr_ch0;
		bus_wr && sel == DACC_SEL_CH0;
	endsequence

	sequence seq_rd_ctrl;
		bus_rd && !bus_wr && sel == DACC_SEL_CTRL;
	endsequence

	sequence seq_wr_ch1;
		bus_wr && sel == DACC_SEL_CH1;
	endsequence

	sequence seq_rd_ch0;
		bus_rd && sel == DACC_SEL_CH0;
	endsequence

	sequence seq_access;
		bus_wr || bus_rd;
	endsequence

	AST_RESET_DATA: assert property (@(posedge clk)
		sys_rst |=> analog_out_ch0 == DACC_DATA_RST
			&& analog_out_ch1 == DACC_DATA_RST && !out_en_ch0 && !out_en_ch1)
		else $error("reset did not clear data and enables");
	AST_WR_CH0: assert property (@(posedge clk) disable iff (sys_rst)
		seq_wr_ch0 |=> analog_out_ch0 == $past(bus_wdata) && bus_ack)
		else $error("channel 0 data write lost");
	AST_RD_CTRL: assert property (@(posedge clk)
		disable iff (sys_rst)
		seq_rd_ctrl |=> bus_rdata[4:0] == 5'h1f
			&& bus_rdata[7] == out_en_ch1 && bus_rdata[6] == out_en_ch0)
		else $error("control read value wrong");
	AST_CONV_INDEP: assert property (@(posedge clk)
		disable iff (sys_rst)
		!s_q.joint_convert_en |-> conv_en_ch0 == out_en_ch0
			&& conv_en_ch1 == out_en_ch1)
		else $error("conversion not independent with joint bit clear");
	AST_CONV_JOINT: assert property (@(posedge clk)
		disable iff (sys_rst)
		(s_q.joint_convert_en && (out_en_ch0 || out_en_ch1))
			|-> conv_en_ch0 && conv_en_ch1)
		else $error("joint conversion not applied");
	AST_OE_CH1: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_wr && sel == DACC_SEL_CTRL) |=> out_en_ch1 == $past(bus_wdata[7])
			&& out_en_ch0 == $past(bus_wdata[6]))
		else $error("output enable did not follow control write");
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (sys_rst)
		(bus_rd && sel == DACC_SEL_NONE) |=> bus_rdata == 8'h00 && bus_ack)
		else $error("unmapped read not answered with zero");
	AST_WR_CH1: assert property (@(posedge clk)
		disable iff (sys_rst)
		seq_wr_ch1 |=> analog_out_ch1 == $past(bus_wdata) && bus_ack)
		else $error("channel 1 data write lost");
	// A write in the same cycle must not leak into the data read back.
	AST_RD_CH0: assert property (@(posedge clk)
		disable iff (sys_rst)
		seq_rd_ch0 |=> bus_rdata == $past(analog_out_ch0) && bus_ack)
		else $error("channel 0 read value wrong");
	AST_ACK_ONE: assert property (@(posedge clk)
		disable iff (sys_rst)
		seq_access |=> bus_ack)
		else $error("access not acknowledged");
	AST_ACK_IDLE: assert property (@(posedge clk)
		disable iff (sys_rst)
		!(bus_wr || bus_rd) |=> !bus_ack)
		else $error("acknowledge without access");
	AST_RD_HOLD: assert property (@(posedge clk)
		disable iff (sys_rst)
		!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");
	AST_RESET_CTRL: assert property (@(posedge clk)
		sys_rst |=> dac_control == DACC_CONTROL_RST)
		else $error("control register not reset");

endmodule

// ===== tb/dacc_stage.sv
`timescale 1ns/1ps
module dacc_stage (
	input wire logic clk,
	input wire logic [7:0] code,
	input wire logic conv_en,
	input wire logic out_en,
	output logic [7:0] pin
);
	logic [7:0] last_q = 8'h00;
	always_ff @(posedge clk) begin
		if (out_en) begin
			last_q <= code;
		end
	end
	// A released pin shows the inverse of its last level, never a stale copy.
	assign pin = (out_en && conv_en) ? code : ~last_q;
endmodule

// ===== tb/dacc_top_bench.sv
`timescale 1ns/1ps
module dacc_top_bench;
	import dacc_pkg::*;
	localparam int SC = 4;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] bus_addr = 32'h00000000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata, ao0, ao1, pin0, pin1;
	logic bus_ack, ce0, ce1, oe0, oe1, ov0, ov1;
	int bad_count = 0;
	int compares = 0;
	dacc_top #(.SETTLE_CYC(SC)) dut_u (.clk(clk), .sys_rst(sys_rst),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.analog_out_ch0(ao0), .analog_out_ch1(ao1), .conv_en_ch0(ce0),
		.conv_en_ch1(ce1), .out_en_ch0(oe0), .out_en_ch1(oe1),
		.out_valid_ch0(ov0), .out_valid_ch1(ov1));
	dacc_stage st0_u (.clk(clk), .code(ao0), .conv_en(ce0), .out_en(oe0),
		.pin(pin0));
	dacc_stage st1_u (.clk(clk), .code(ao1), .conv_en(ce1), .out_en(oe1),
		.pin(pin1));
	initial begin
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One access; the strobe is dropped and a clock passes before return.
	task automatic acc(logic w, logic [31:0] a, logic [7:0] d);
		bus_addr = a;
		bus_wr = w;
		bus_rd = !w;
		bus_wdata = d;
		@(negedge clk);
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		chk("bus_ack", 8'h01, {7'h00, bus_ack});
		if (!w) begin
			chk("bus_rdata", d, bus_rdata);
		end
		@(negedge clk);
	endtask
	task automatic settle(int ch);
		int n;
		n = 0;
		while (n < 20 && (ch ? ov1 : ov0) !== 1'b1) begin
			@(negedge clk);
			n++;
		end
		chk("settle_cycles", 8'(SC - 1), n[7:0]);
		if (n == 20) begin
			conclude();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		acc(1'b0, DACC_ADDR_DATA_CH0, 8'h00);
		acc(1'b0, DACC_ADDR_DATA_CH1, 8'h00);
		acc(1'b0, DACC_ADDR_CONTROL, 8'h1f);
		chk("out_en_ch0", 8'h00, {7'h00, oe0});
		acc(1'b1, DACC_ADDR_DATA_CH0, 8'h55);
		acc(1'b1, DACC_ALIAS_DATA_CH1, 8'haa);
		acc(1'b1, 32'h040000a6, 8'h77);
		acc(1'b0, DACC_ALIAS_DATA_CH0, 8'h55);
		acc(1'b0, DACC_ADDR_DATA_CH1, 8'haa);
		acc(1'b0, 32'h040000a6, 8'h00);
		chk("analog_out_ch1", 8'haa, ao1);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, DACC_ALIAS_CONTROL, {i[2:0], 5'h00});
			acc(1'b0, DACC_ADDR_CONTROL, {i[2:0], 5'h1f});
			chk("out_en_ch1", {7'h00, i[2]}, {7'h00, oe1});
			chk("out_en_ch0", {7'h00, i[1]}, {7'h00, oe0});
			chk("conv_en_ch0", {7'h00, i[1] | (i[0] & i[2])},
				{7'h00, ce0});
			chk("conv_en_ch1", {7'h00, i[2] | (i[0] & i[1])},
				{7'h00, ce1});
		end
		acc(1'b1, DACC_ADDR_CONTROL, 8'h00);
		acc(1'b1, DACC_ADDR_CONTROL, 8'h40);
		settle(0);
		chk("pin_ch0", 8'h55, pin0);
		chk("out_valid_ch1", 8'h00, {7'h00, ov1});
		acc(1'b1, DACC_ADDR_DATA_CH0, 8'h3c);
		chk("out_valid_ch0", 8'h00, {7'h00, ov0});
		settle(0);
		chk("pin_ch0", 8'h3c, pin0);
		acc(1'b1, DACC_ADDR_CONTROL, 8'h80);
		settle(1);
		chk("pin_ch1", 8'haa, pin1);
		conclude();
	end
endmodule
